// ==== bench/lane_receiver_model.sv ====
// Receiver model: rebuilds sample frames from the lane octets.
// Assumes lane outputs and strobes are registered on i_sys_clk.
`timescale 1ns/10ps
`default_nettype none

module lane_receiver_model (
  // Clock and reset
  input  wire logic         i_sys_clk,
  input  wire logic         i_rst,
  // Lanes, a0..a3 then b0..b3
  input  wire logic [7:0]   i_a0,
  input  wire logic [7:0]   i_a1,
  input  wire logic [7:0]   i_a2,
  input  wire logic [7:0]   i_a3,
  input  wire logic [7:0]   i_b0,
  input  wire logic [7:0]   i_b1,
  input  wire logic [7:0]   i_b2,
  input  wire logic [7:0]   i_b3,
  input  wire logic         i_octet_valid,
  input  wire logic         i_frame_start,
  input  wire logic [7:0]   i_lane_active,
  // Rebuilt frame
  output logic              o_done,
  output logic [127:0]      o_frame
);
  // ----------------------------------------------------------------------
  // Octet capture
  // ----------------------------------------------------------------------
  logic [7:0]  lane [8];
  logic [31:0] acc_q [8];
  logic [2:0]  cnt_q;
  logic        four_q;
  logic        run_q;
  logic [2:0]  cnt_d;

  assign lane = '{i_a0, i_a1, i_a2, i_a3, i_b0, i_b1, i_b2, i_b3};
  assign cnt_d = i_frame_start ? 3'h1 : cnt_q + 3'h1;

  // Octets outside a frame are dropped, so underrun gaps never shift a frame
  always_ff @(posedge i_sys_clk) begin
    o_done <= 1'b0;
    if (i_rst) begin
      run_q <= 1'b0;
      cnt_q <= 3'h0;
    end else if (i_octet_valid && (i_frame_start || run_q)) begin
      for (int l = 0; l < 8; l++) acc_q[l] <= {acc_q[l][23:0], lane[l]};
      if (i_frame_start) four_q <= (i_lane_active == 8'h66);
      cnt_q <= cnt_d;
      run_q <= 1'b1;
      if (cnt_d == ((i_frame_start ? (i_lane_active == 8'h66) : four_q) ? 3'h4 : 3'h2)) begin
        o_done <= 1'b1;
        run_q  <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Stream mapping, stream k at bits 16k
  // ----------------------------------------------------------------------
  always_comb begin
    for (int k = 0; k < 8; k++) o_frame[16*k +: 16] = acc_q[k][15:0];
    if (four_q) begin
      // Each lane holds I in its upper half, Q in its lower half
      o_frame = {acc_q[6][15:0], acc_q[6][31:16], acc_q[5][15:0], acc_q[5][31:16],
                 acc_q[2][15:0], acc_q[2][31:16], acc_q[1][15:0], acc_q[1][31:16]};
    end
  end
endmodule : lane_receiver_model
`default_nettype wire

// ==== bench/tb.sv ====
// Self-checking bench for the dual-band lane framer and its receiver.
// Assumes a 100 MHz clock; inputs change at the falling edge.
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin mismatches++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end

module tb;
  // ----------------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------------
  logic         clk = 1'b0;
  logic         rst = 1'b1;
  logic [1:0]   sel0 = 2'h1;
  logic         sel1 = 1'h0;
  logic         sel2 = 1'h0;
  logic [5:0]   dec = 6'h08;
  logic         valid = 1'b0;
  logic [127:0] data = '0;
  logic         ready, oct_v, fs, cfg_err, underrun, rx_done;
  logic [7:0]   a0, a1, a2, a3, b0, b1, b2, b3, act, cur_act;
  logic [127:0] rx_frame, exp;
  logic [127:0] q [$];
  int           mismatches = 0;
  int           compares = 0;
  int           seed = 50248;
  int           oct_cnt = 0;
  int           fs_prev = 0;
  int           fs_last = 0;
  int           n;
  int           t0;
  logic [5:0]   dec8 [7] = '{6'h08, 6'h09, 6'h0a, 6'h0c, 6'h10, 6'h12, 6'h14};
  logic [5:0]   dec4 [9] = '{6'h08, 6'h09, 6'h0a, 6'h0c, 6'h10, 6'h12, 6'h14, 6'h18, 6'h20};
  logic [9:0]   bad [6] = '{{4'h4, 6'h18}, {4'h4, 6'h20}, {4'h0, 6'h08}, {4'hc, 6'h08},
                            {4'h6, 6'h08}, {4'h9, 6'h08}};

  always #5 clk = ~clk;

  dual_band_lane_framer dual_band_lane_framer_i (
    .i_sys_clk(clk), .i_rst(rst), .i_format_sel0(sel0), .i_format_sel1(sel1),
    .i_format_sel2(sel2), .i_decim_factor(dec), .i_smp_valid(valid), .i_smp_data(data),
    .o_smp_ready(ready), .o_lane_a_zero(a0), .o_lane_a_one(a1), .o_lane_a_two(a2),
    .o_lane_a_three(a3), .o_lane_b_zero(b0), .o_lane_b_one(b1), .o_lane_b_two(b2),
    .o_lane_b_three(b3), .o_octet_valid(oct_v), .o_frame_start(fs),
    .o_lane_active(act), .o_cfg_error(cfg_err), .o_underrun(underrun));

  lane_receiver_model lane_receiver_model_i (
    .i_sys_clk(clk), .i_rst(rst), .i_a0(a0), .i_a1(a1), .i_a2(a2), .i_a3(a3),
    .i_b0(b0), .i_b1(b1), .i_b2(b2), .i_b3(b3), .i_octet_valid(oct_v),
    .i_frame_start(fs), .i_lane_active(act), .o_done(rx_done), .o_frame(rx_frame));

  // ----------------------------------------------------------------------
  // Result watcher
  // ----------------------------------------------------------------------
  always @(posedge clk) begin
    if (oct_v === 1'b1) oct_cnt++;
    // Last two frame starts; the first frame after a format change may run long
    if (fs === 1'b1) begin
      fs_prev = fs_last;
      fs_last = int'($time);
    end
    if (oct_v === 1'b1 && cur_act == 8'h66) `CHK({a0, a3, b0, b3}, 32'h0)
    if (rx_done === 1'b1) begin
      exp = (q.size() > 0) ? q.pop_front() : ~rx_frame;
      `CHK(rx_frame, exp)
      `CHK(act, cur_act)
    end
  end

  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  function automatic logic [127:0] rnd();
    return {$random(seed), $random(seed), $random(seed), $random(seed)};
  endfunction : rnd

  task automatic push(input logic [127:0] d);
    @(negedge clk);
    while (ready !== 1'b1) @(negedge clk);
    valid = 1'b1;
    data = d;
    q.push_back(d);
    @(negedge clk);
    valid = 1'b0;
  endtask : push

  task automatic drain(input int lim);
    int k;
    k = 0;
    while (q.size() > 0 && k < lim) begin
      @(posedge clk);
      k++;
    end
    `CHK(q.size(), 0)
    repeat (4) @(posedge clk);
  endtask : drain

  task automatic run_cfg(input logic [1:0] s0, input logic [5:0] d);
    @(negedge clk);
    sel0 = s0;
    dec = d;
    cur_act = (s0 == 2'h1) ? 8'hff : 8'h66;
    #1 `CHK(cfg_err, 1'b0)
    repeat (3) push(rnd());
    drain(400);
    `CHK((fs_last - fs_prev) / 10, int'(d))
    $display("test format %0d factor %0d done", s0, d);
  endtask : run_cfg

  task automatic test_done();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : test_done

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    cur_act = 8'hff;
    repeat (16) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    foreach (dec8[i]) run_cfg(2'h1, dec8[i]);
    foreach (dec4[i]) run_cfg(2'h2, dec4[i]);
    // Refused pairs and stray select bits
    foreach (bad[i]) begin
      @(negedge clk);
      {sel0, sel1, sel2, dec} = bad[i];
      #1 `CHK(cfg_err, 1'b1)
    end
    $display("test refused configs done");
    // Fill while idle: nothing may leave, the buffer must refuse at 32
    @(negedge clk);
    {sel0, sel1, sel2, dec} = {4'h4, 6'h18};
    cur_act = 8'h00;
    repeat (60) @(posedge clk);
    `CHK(act, 8'h00)
    t0 = oct_cnt;
    n = 0;
    repeat (40) begin
      @(negedge clk);
      valid = ready;
      data = rnd();
      if (ready === 1'b1) begin
        q.push_back(data);
        n++;
      end
    end
    @(negedge clk);
    valid = 1'b0;
    `CHK(n, 32)
    `CHK(ready, 1'b0)
    `CHK(oct_cnt - t0, 0)
    sel0 = 2'h2;
    dec = 6'h08;
    cur_act = 8'h66;
    drain(32 * 8 + 300);
    $display("test fill and drain done");
    // Empty buffer at a frame boundary: flag and quiet lanes
    n = 0;
    while (underrun !== 1'b1 && n < 40) begin
      @(posedge clk);
      n++;
    end
    `CHK(underrun, 1'b1)
    `CHK({a0, a1, a2, a3, b0, b1, b2, b3}, 64'h0)
    $display("test underrun done");
    test_done();
  end

  initial begin
    repeat (30000) @(posedge clk);
    mismatches++;
    test_done();
  end
endmodule : tb
`default_nettype wire

// ==== hw/dual_band_lane_framer.sv ====
// Dual-band complex frame assembler: eight I/Q streams onto eight or four lanes.
// Assumes samples and configuration come from logic on i_sys_clk.
`timescale 1ns/10ps
`default_nettype none
`include "lane_framer_cfg.svh"

module dual_band_lane_framer (
  // Clock and reset
  input  wire logic         i_sys_clk,
  input  wire logic         i_rst,
  // Configuration
  input  wire logic [1:0]   i_format_sel0,
  input  wire logic         i_format_sel1,
  input  wire logic         i_format_sel2,
  input  wire logic [5:0]   i_decim_factor,
  // Sample frames in
  input  wire logic         i_smp_valid,
  input  wire logic [127:0] i_smp_data,
  output logic              o_smp_ready,
  // Lanes
  output logic [7:0]        o_lane_a_zero,
  output logic [7:0]        o_lane_a_one,
  output logic [7:0]        o_lane_a_two,
  output logic [7:0]        o_lane_a_three,
  output logic [7:0]        o_lane_b_zero,
  output logic [7:0]        o_lane_b_one,
  output logic [7:0]        o_lane_b_two,
  output logic [7:0]        o_lane_b_three,
  // Lane status
  output logic              o_octet_valid,
  output logic              o_frame_start,
  output logic [7:0]        o_lane_active,
  output logic              o_cfg_error,
  output logic              o_underrun
);

  // ----------------------------------------------------------------------
  // Format decode
  // ----------------------------------------------------------------------
  lane_framer_pkg::lane_format_t  fmt;
  lane_framer_pkg::lane_format_t  fmt_q;
  lane_framer_pkg::framer_state_t state_q;
  logic                           cfg_ok;
  logic [5:0]                     decim_q;
  logic [2:0]                     oct_per_frame;
  logic                           factor_short;
  logic                           factor_long;

  always_comb begin
    factor_short = 1'b0;
    factor_long  = 1'b0;
    unique case (i_decim_factor)
      `LF_DEC_8, `LF_DEC_9, `LF_DEC_10, `LF_DEC_12,
      `LF_DEC_16, `LF_DEC_18, `LF_DEC_20: factor_short = 1'b1;
      `LF_DEC_24, `LF_DEC_32:             factor_long  = 1'b1;
      default:                            factor_short = 1'b0;
    endcase
  end

  // Illegal pairs never start a frame, so a bad setting cannot overrun lanes
  always_comb begin
    fmt = lane_framer_pkg::FMT_NONE;
    if (i_format_sel1 == `LF_SEL12_ZERO && i_format_sel2 == `LF_SEL12_ZERO) begin
      if (i_format_sel0 == `LF_SEL0_EIGHT && factor_short) begin
        fmt = lane_framer_pkg::FMT_EIGHT;
      end else if (i_format_sel0 == `LF_SEL0_FOUR && (factor_short || factor_long)) begin
        fmt = lane_framer_pkg::FMT_FOUR;
      end
    end
  end

  assign cfg_ok        = (fmt != lane_framer_pkg::FMT_NONE);
  assign oct_per_frame = (fmt_q == lane_framer_pkg::FMT_FOUR) ? `LF_OCT_FOUR : `LF_OCT_EIGHT;

  // ----------------------------------------------------------------------
  // Buffering and octet rate
  // ----------------------------------------------------------------------
  logic         fifo_valid;
  logic [127:0] fifo_data;
  logic         pop;
  logic         strobe;
  logic [1:0]   idx_q;
  logic         boundary;
  logic         last_oct;

  sample_fifo #(
    .WIDTH (`LF_FRAME_W),
    .DEPTH (`LF_FIFO_DEPTH)
  ) u_fifo (
    .i_sys_clk   (i_sys_clk),
    .i_rst       (i_rst),
    .i_in_valid  (i_smp_valid),
    .i_in_data   (i_smp_data),
    .o_in_ready  (o_smp_ready),
    .o_out_valid (fifo_valid),
    .o_out_data  (fifo_data),
    .i_out_ready (pop)
  );

  octet_rate_divider u_rate (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .i_run     (state_q == lane_framer_pkg::ST_RUN),
    .i_octets  (oct_per_frame),
    .i_decim   (decim_q),
    .o_strobe  (strobe)
  );

  assign boundary = strobe && (idx_q == 2'h0);
  assign pop      = boundary && fifo_valid && cfg_ok;
  assign last_oct = ({1'b0, idx_q} == oct_per_frame - 3'h1);

  // ----------------------------------------------------------------------
  // Control state
  // ----------------------------------------------------------------------
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      state_q <= lane_framer_pkg::ST_IDLE;
      fmt_q   <= lane_framer_pkg::FMT_NONE;
      decim_q <= `LF_DEC_8;
    end else begin
      unique case (state_q)
        lane_framer_pkg::ST_IDLE: begin
          if (cfg_ok) begin
            state_q <= lane_framer_pkg::ST_RUN;
            fmt_q   <= fmt;
            decim_q <= i_decim_factor;
          end
        end
        lane_framer_pkg::ST_RUN: begin
          // Format only changes between frames
          if (boundary) begin
            if (cfg_ok) begin
              fmt_q   <= fmt;
              decim_q <= i_decim_factor;
            end else begin
              state_q <= lane_framer_pkg::ST_IDLE;
              fmt_q   <= lane_framer_pkg::FMT_NONE;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      idx_q <= 2'h0;
    end else if (strobe && (idx_q != 2'h0 || pop)) begin
      idx_q <= last_oct ? 2'h0 : idx_q + 2'h1;
    end
  end

  assign o_cfg_error = !cfg_ok;

  // ----------------------------------------------------------------------
  // Octet selection
  // ----------------------------------------------------------------------
  logic [127:0] frame_q;
  logic [127:0] frame_src;
  logic [63:0]  lanes_q;
  logic [63:0]  lanes_d;
  lane_framer_pkg::lane_format_t fmt_use;

  assign frame_src = (idx_q == 2'h0) ? fifo_data : frame_q;
  assign fmt_use   = (idx_q == 2'h0) ? fmt : fmt_q;

  // Stream k of the frame sits at bits 16k: A1I,A1Q,A2I,A2Q,B1I,B1Q,B2I,B2Q
  function automatic logic [7:0] pick(input logic [127:0] frame,
                                      input logic [3:0]   stream,
                                      input logic         low);
    logic [15:0] s;
    s = frame[stream*16 +: 16];
    return low ? s[7:0] : s[15:8];
  endfunction : pick

  always_comb begin
    lanes_d = 64'h0;
    for (int ch = 0; ch < 2; ch++) begin
      for (int ln = 0; ln < 4; ln++) begin
        if (fmt_use == lane_framer_pkg::FMT_EIGHT) begin
          lanes_d[(ch*4+ln)*8 +: 8] = pick(frame_src, 4'(ch*4+ln), idx_q[0]);
        end else if (fmt_use == lane_framer_pkg::FMT_FOUR && (ln == 1 || ln == 2)) begin
          lanes_d[(ch*4+ln)*8 +: 8] =
            pick(frame_src, 4'(ch*4 + (ln-1)*2 + int'(idx_q[1])), idx_q[0]);
        end
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (pop) begin
      frame_q <= fifo_data;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      lanes_q       <= 64'h0;
      o_octet_valid <= 1'b0;
      o_frame_start <= 1'b0;
      o_underrun    <= 1'b0;
      o_lane_active <= `LF_ACT_NONE;
    end else begin
      o_octet_valid <= pop || (strobe && idx_q != 2'h0);
      o_frame_start <= pop;
      o_underrun    <= boundary && !fifo_valid && cfg_ok;
      if (pop || (strobe && idx_q != 2'h0)) begin
        lanes_q <= lanes_d;
      end else if (boundary) begin
        lanes_q <= 64'h0;
      end
      if (pop) begin
        o_lane_active <= (fmt == lane_framer_pkg::FMT_FOUR) ? `LF_ACT_FOUR : `LF_ACT_EIGHT;
      end else if (boundary && !cfg_ok) begin
        o_lane_active <= `LF_ACT_NONE;
      end
    end
  end

  assign o_lane_a_zero  = lanes_q[7:0];
  assign o_lane_a_one   = lanes_q[15:8];
  assign o_lane_a_two   = lanes_q[23:16];
  assign o_lane_a_three = lanes_q[31:24];
  assign o_lane_b_zero  = lanes_q[39:32];
  assign o_lane_b_one   = lanes_q[47:40];
  assign o_lane_b_two   = lanes_q[55:48];
  assign o_lane_b_three = lanes_q[63:56];

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  frame_capture_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    pop |=> (frame_q == $past(fifo_data)) && o_frame_start)
    else $error("frame not captured whole");

  eight_octets_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (strobe && fmt_q == lane_framer_pkg::FMT_EIGHT && idx_q != 2'h0) |=> (idx_q == 2'h0))
    else $error("eight-lane frame length wrong");

  four_active_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (strobe && fmt_q == lane_framer_pkg::FMT_FOUR && idx_q != 2'h0) |=>
      (idx_q == $past(idx_q) + 2'h1))
    else $error("four-lane octet count wrong");

  long_factor_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (fmt_q == lane_framer_pkg::FMT_EIGHT) |-> (decim_q <= `LF_DEC_20))
    else $error("eight-lane at long factor");

  // Four-lane at factor 8 strobes every second cycle, so only back-to-back is wrong
  octet_spacing_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    strobe |=> !strobe)
    else $error("octet strobes too close");

  eight_order_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (o_frame_start && o_lane_active == `LF_ACT_EIGHT) |->
      (o_lane_a_zero == frame_q[15:8]) && (o_lane_a_three == frame_q[63:56]))
    else $error("eight-lane upper byte misplaced");

  four_order_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (o_frame_start && o_lane_active == `LF_ACT_FOUR) |->
      (o_lane_a_one == frame_q[15:8]) && (o_lane_a_two == frame_q[47:40]))
    else $error("four-lane first octet misplaced");

  channel_split_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (o_frame_start && o_lane_active == `LF_ACT_EIGHT) |->
      (o_lane_b_zero == frame_q[79:72]) && (o_lane_b_two == frame_q[111:104]))
    else $error("channel B lanes misplaced");

  idle_lanes_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (o_octet_valid && o_lane_active == `LF_ACT_FOUR) |->
      (o_lane_a_zero == 8'h00) && (o_lane_b_three == 8'h00))
    else $error("unused lane not idle");

endmodule : dual_band_lane_framer

`default_nettype wire

// ==== hw/octet_rate_divider.sv ====
// Fractional divider: octets per frame spread over decimation-factor cycles.
// Assumes one i_sys_clk cycle stands for one converter sample clock.
`timescale 1ns/10ps
`default_nettype none

module octet_rate_divider (
  // Clock and reset
  input  wire logic       i_sys_clk,
  input  wire logic       i_rst,
  // Control
  input  wire logic       i_run,
  input  wire logic [2:0] i_octets,
  input  wire logic [5:0] i_decim,
  // Octet enable
  output logic            o_strobe
);

  logic [5:0] acc_q;
  logic [5:0] acc_d;
  logic       hit;

  // Octets per frame never exceed the factor, so at most one strobe a cycle
  always_comb begin
    acc_d = acc_q + {3'h0, i_octets};
    hit   = (acc_d >= i_decim);
    if (hit) begin
      acc_d = acc_d - i_decim;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst || !i_run) begin
      acc_q    <= 6'h00;
      o_strobe <= 1'b0;
    end else begin
      acc_q    <= acc_d;
      o_strobe <= hit;
    end
  end

endmodule : octet_rate_divider

`default_nettype wire

// ==== hw/sample_fifo.sv ====
// Synchronous FIFO of whole sample frames with valid/ready on both sides.
// Assumes both sides run on i_sys_clk.
`timescale 1ns/10ps
`default_nettype none

module sample_fifo #(
  parameter int WIDTH = 128,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input  wire logic             i_sys_clk,
  input  wire logic             i_rst,
  // Fill side
  input  wire logic             i_in_valid,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_in_ready,
  // Drain side
  output logic                  o_out_valid,
  output logic [WIDTH-1:0]      o_out_data,
  input  wire logic             i_out_ready
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_q;
  logic [AW-1:0]    rd_ptr_q;
  logic [AW:0]      count_q;
  logic             push;
  logic             pop;

  assign o_in_ready  = (count_q != (AW+1)'(DEPTH));
  assign o_out_valid = (count_q != '0);
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;
  assign o_out_data  = mem[rd_ptr_q];

  always_ff @(posedge i_sys_clk) begin
    if (push) begin
      mem[wr_ptr_q] <= i_in_data;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
      count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

endmodule : sample_fifo

`default_nettype wire

// ==== shared/lane_framer_cfg.svh ====
// Constants for the dual-band complex lane framer: formats, sizes, rates.
// Assumes inclusion by bare name from files that need these values.
`ifndef LANE_FRAMER_CFG_SVH
`define LANE_FRAMER_CFG_SVH

// ----------------------------------------------------------------------
// Format select codes
// ----------------------------------------------------------------------
`define LF_SEL0_EIGHT   2'h1
`define LF_SEL0_FOUR    2'h2
`define LF_SEL12_ZERO   1'h0

// ----------------------------------------------------------------------
// Frame geometry
// ----------------------------------------------------------------------
`define LF_SAMPLE_W     16
`define LF_STREAMS      8
`define LF_FRAME_W      128
`define LF_LANES        8
`define LF_OCT_EIGHT    3'h2
`define LF_OCT_FOUR     3'h4
`define LF_ACT_EIGHT    8'hff
`define LF_ACT_FOUR     8'h66
`define LF_ACT_NONE     8'h00
`define LF_FIFO_DEPTH   32

// ----------------------------------------------------------------------
// Decimation factors
// ----------------------------------------------------------------------
`define LF_DEC_8        6'h08
`define LF_DEC_9        6'h09
`define LF_DEC_10       6'h0a
`define LF_DEC_12       6'h0c
`define LF_DEC_16       6'h10
`define LF_DEC_18       6'h12
`define LF_DEC_20       6'h14
`define LF_DEC_24       6'h18
`define LF_DEC_32       6'h20

`endif

// ==== shared/lane_framer_pkg.sv ====
// Types shared by the dual-band complex lane framer.
// Assumes nothing of its surroundings.
`default_nettype none
package lane_framer_pkg;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    FMT_NONE  = 2'b00,
    FMT_EIGHT = 2'b01,
    FMT_FOUR  = 2'b10
  } lane_format_t;

  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_RUN  = 1'b1
  } framer_state_t;

endpackage : lane_framer_pkg

`default_nettype wire
